// >>> logic/eeis_pkg.sv
package eeis_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TMR_CTRL = 8'h88;
	localparam logic [7:0] IDX_A_FALL = 8'hBA;
	localparam logic [7:0] IDX_A_RISE = 8'hBB;
	localparam logic [7:0] IDX_B_FALL = 8'hBC;
	localparam logic [7:0] IDX_B_RISE = 8'hBD;
	localparam logic [7:0] IDX_C_FALL = 8'hC6;
	localparam logic [7:0] IDX_C_RISE = 8'hC7;
	localparam logic [7:0] IDX_IRQ_CTRL = 8'hD0;
	localparam logic [7:0] IDX_IRQ_STAT = 8'hD1;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hD2;
	localparam int ADDR_W = 12;
	// Field positions
	localparam int TMR_B_FLAG = 3;
	localparam int TMR_A_FLAG = 1;
	localparam int CTRL_C_EN = 3;
	localparam int CTRL_A_PRIO = 0;
	localparam int EV_A = 0;
	localparam int EV_B = 1;
	localparam int EV_C = 2;
	// Implemented bits per register
	localparam logic [7:0] MASK_A_EN = 8'h0E;
	localparam logic [7:0] MASK_B_EN = 8'h0F;
	localparam logic [7:0] MASK_C_EN = 8'h3F;
	localparam logic [7:0] MASK_TMR = 8'h0A;
	localparam logic [7:0] MASK_CTRL = 8'h09;
	localparam logic [7:0] MASK_EV = 8'h07;
	// Value after reset; bus response codes
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/eeis_edge_detect.sv
`timescale 1ns/1ps
// Per-line edge detector OR-ed into one group event
module eeis_edge_detect #(
	parameter int N = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [N-1:0] lines,
	input wire logic [N-1:0] rise_en,
	input wire logic [N-1:0] fall_en,
	output logic event_o
);
	import eeis_pkg::*;
	logic [N-1:0] prev_r, prev_nxt;
	logic [N-1:0] hit;
	logic primed_r, primed_nxt;
	logic event_r, event_nxt;

	// Per-line detection; both enables give either edge
	for (genvar i = 0; i < N; i++) begin : g_line
		assign hit[i] = primed_r & ((rise_en[i] & lines[i] & ~prev_r[i]) |
			(fall_en[i] & ~lines[i] & prev_r[i]));
	end

	// First sample only primes, so a high line at reset is no edge
	always_comb begin
		prev_nxt = lines;
		primed_nxt = 1'h1;
		event_nxt = |hit;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_r <= '0;
			primed_r <= 1'h0;
			event_r <= 1'h0;
		end else if (ce) begin
			prev_r <= prev_nxt;
			primed_r <= primed_nxt;
			event_r <= event_nxt;
		end
	end

	assign event_o = event_r;

	edge_seen_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && (|hit) |=> event_o)
		else $error("enabled edge gave no event");
	edge_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !(|hit) |=> !event_o)
		else $error("event without enabled edge");
endmodule

// >>> logic/eeis_axil_slave.sv
`timescale 1ns/1ps
// AXI4-Lite slave front end, one write and one read at a time
module eeis_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [eeis_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [eeis_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [eeis_pkg::ADDR_W-1:0] wr_addr,
	output logic [7:0] wr_data,
	output logic wr_byte,
	input wire logic wr_hit,
	output logic rd_en,
	output logic [eeis_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic rd_hit
);
	import eeis_pkg::*;
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic aw_take, w_take;

	// Ready only while the channel slot is free
	assign s_axi_awready = ce & ~aw_got_r & ~bvalid_r;
	assign s_axi_wready = ce & ~w_got_r & ~bvalid_r;
	assign s_axi_arready = ce & ~rvalid_r;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	// Write executes once both halves are held, in either order
	assign wr_en = ce & ~bvalid_r & (aw_got_r | aw_take) & (w_got_r | w_take);
	assign wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
	assign wr_data = w_got_r ? wdata_r : s_axi_wdata[7:0];
	assign wr_byte = w_got_r ? wstrb_r : s_axi_wstrb[0];
	assign rd_en = s_axi_arvalid & s_axi_arready;
	assign rd_addr = s_axi_araddr;

	always_comb begin
		aw_got_nxt = (aw_got_r | aw_take) & ~wr_en;
		w_got_nxt = (w_got_r | w_take) & ~wr_en;
		awaddr_nxt = aw_take ? s_axi_awaddr : awaddr_r;
		wdata_nxt = w_take ? s_axi_wdata[7:0] : wdata_r;
		wstrb_nxt = w_take ? s_axi_wstrb[0] : wstrb_r;
		bvalid_nxt = wr_en | (bvalid_r & ~s_axi_bready);
		bresp_nxt = wr_en ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_r;
		rvalid_nxt = rd_en | (rvalid_r & ~s_axi_rready);
		rdata_nxt = rd_en ? rd_data : rdata_r;
		rresp_nxt = rd_en ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : rresp_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'h0;
			w_got_r <= 1'h0;
			awaddr_r <= '0;
			wdata_r <= RST_REG;
			wstrb_r <= 1'h0;
			bvalid_r <= 1'h0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'h0;
			rdata_r <= RST_REG;
			rresp_r <= RESP_OKAY;
		end else if (ce) begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Narrow registers sit in the low byte
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = {24'h000000, rdata_r};
endmodule

// >>> logic/eeis_top.sv
`timescale 1ns/1ps
module eeis_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [eeis_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [eeis_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:1] ext_irq_group_a,
	input wire logic [3:0] ext_irq_group_b,
	input wire logic [5:0] ext_irq_group_c,
	input wire logic cpu_ack_a,
	input wire logic cpu_ack_b,
	output logic group_a_request_flag,
	output logic group_b_request_flag,
	output logic group_c_request,
	output logic group_a_priority_sel,
	output logic irq
);
	import eeis_pkg::*;
	logic wr_en, wr_byte, wr_hit, rd_en, rd_hit;
	logic [ADDR_W-1:0] wr_addr, rd_addr;
	logic [7:0] wr_data, rd_data;
	logic [7:0] wr_idx, rd_idx;
	logic wr_ok, rd_top_ok;
	logic ev_a, ev_b, ev_c;
	logic [2:0] events;
	logic [7:0] a_fall_r, a_fall_nxt, a_rise_r, a_rise_nxt;
	logic [7:0] b_fall_r, b_fall_nxt, b_rise_r, b_rise_nxt;
	logic [7:0] c_fall_r, c_fall_nxt, c_rise_r, c_rise_nxt;
	logic [7:0] ctrl_r, ctrl_nxt, stat_r, stat_nxt, mask_r, mask_nxt;
	logic flag_a_r, flag_a_nxt, flag_b_r, flag_b_nxt;
	logic c_req_r, c_req_nxt, irq_r, irq_nxt;

	eeis_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_byte(wr_byte),
		.wr_hit(wr_hit),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// group A edge enables gate lines 3..1
	eeis_edge_detect #(.N(3)) u_edge_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.lines(ext_irq_group_a),
		.rise_en(a_rise_r[3:1]),
		.fall_en(a_fall_r[3:1]),
		.event_o(ev_a)
	);

	// group B edge enables gate lines 3..0
	eeis_edge_detect #(.N(4)) u_edge_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.lines(ext_irq_group_b),
		.rise_en(b_rise_r[3:0]),
		.fall_en(b_fall_r[3:0]),
		.event_o(ev_b)
	);

	// group C edge enables gate lines 5..0
	eeis_edge_detect #(.N(6)) u_edge_c (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.lines(ext_irq_group_c),
		.rise_en(c_rise_r[5:0]),
		.fall_en(c_fall_r[5:0]),
		.event_o(ev_c)
	);

	assign events = {ev_c, ev_b, ev_a};
	// Word index; upper address bits must be zero to hit
	assign wr_idx = wr_addr[9:2];
	assign rd_idx = rd_addr[9:2];
	assign wr_ok = (wr_addr[ADDR_W-1:10] == '0) & (wr_addr[1:0] == 2'h0);
	assign rd_top_ok = (rd_addr[ADDR_W-1:10] == '0) & (rd_addr[1:0] == 2'h0);

	// Read decode; reserved and timer bits read zero
	always_comb begin
		rd_data = RST_REG;
		rd_hit = rd_top_ok;
		if (rd_idx == IDX_TMR_CTRL) begin
			rd_data[TMR_B_FLAG] = flag_b_r;
			rd_data[TMR_A_FLAG] = flag_a_r;
		end else if (rd_idx == IDX_A_FALL) begin
			rd_data = a_fall_r;
		end else if (rd_idx == IDX_A_RISE) begin
			rd_data = a_rise_r;
		end else if (rd_idx == IDX_B_FALL) begin
			rd_data = b_fall_r;
		end else if (rd_idx == IDX_B_RISE) begin
			rd_data = b_rise_r;
		end else if (rd_idx == IDX_C_FALL) begin
			rd_data = c_fall_r;
		end else if (rd_idx == IDX_C_RISE) begin
			rd_data = c_rise_r;
		end else if (rd_idx == IDX_IRQ_CTRL) begin
			rd_data = ctrl_r;
		end else if (rd_idx == IDX_IRQ_STAT) begin
			rd_data = stat_r;
		end else if (rd_idx == IDX_IRQ_MASK) begin
			rd_data = mask_r;
		end else begin
			rd_hit = 1'h0;
		end
	end

	// Write decode; a write with byte 0 off still answers OKAY
	always_comb begin
		a_fall_nxt = a_fall_r;
		a_rise_nxt = a_rise_r;
		b_fall_nxt = b_fall_r;
		b_rise_nxt = b_rise_r;
		c_fall_nxt = c_fall_r;
		c_rise_nxt = c_rise_r;
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		wr_hit = wr_ok;
		if (!wr_en) begin
			wr_hit = wr_ok;
		end else if (wr_idx == IDX_TMR_CTRL) begin
			wr_hit = wr_ok;
		end else if (wr_idx == IDX_A_FALL) begin
			if (wr_byte) a_fall_nxt = wr_data & MASK_A_EN;
		end else if (wr_idx == IDX_A_RISE) begin
			if (wr_byte) a_rise_nxt = wr_data & MASK_A_EN;
		end else if (wr_idx == IDX_B_FALL) begin
			if (wr_byte) b_fall_nxt = wr_data & MASK_B_EN;
		end else if (wr_idx == IDX_B_RISE) begin
			if (wr_byte) b_rise_nxt = wr_data & MASK_B_EN;
		end else if (wr_idx == IDX_C_FALL) begin
			if (wr_byte) c_fall_nxt = wr_data & MASK_C_EN;
		end else if (wr_idx == IDX_C_RISE) begin
			if (wr_byte) c_rise_nxt = wr_data & MASK_C_EN;
		end else if (wr_idx == IDX_IRQ_CTRL) begin
			if (wr_byte) ctrl_nxt = wr_data & MASK_CTRL;
		end else if (wr_idx == IDX_IRQ_STAT) begin
			wr_hit = wr_ok;
		end else if (wr_idx == IDX_IRQ_MASK) begin
			if (wr_byte) mask_nxt = wr_data & MASK_EV;
		end else begin
			wr_hit = 1'h0;
		end
	end

	// Request flags; a new event beats both ack and software clear
	always_comb begin
		flag_a_nxt = flag_a_r & ~cpu_ack_a;
		flag_b_nxt = flag_b_r & ~cpu_ack_b;
		if (wr_en && wr_ok && wr_byte && wr_idx == IDX_TMR_CTRL) begin
			flag_a_nxt = wr_data[TMR_A_FLAG];
			flag_b_nxt = wr_data[TMR_B_FLAG];
		end
		flag_a_nxt = flag_a_nxt | ev_a;
		flag_b_nxt = flag_b_nxt | ev_b;
		c_req_nxt = ev_c & ctrl_r[CTRL_C_EN];
	end

	// Sticky status, write one to clear, set wins
	always_comb begin
		stat_nxt = stat_r;
		if (wr_en && wr_ok && wr_byte && wr_idx == IDX_IRQ_STAT) begin
			stat_nxt = stat_r & ~(wr_data & MASK_EV);
		end
		stat_nxt = stat_nxt | {5'h00, events};
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	// All state frozen while clock enable is low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_fall_r <= RST_REG;
			a_rise_r <= RST_REG;
			b_fall_r <= RST_REG;
			b_rise_r <= RST_REG;
			c_fall_r <= RST_REG;
			c_rise_r <= RST_REG;
			ctrl_r <= RST_REG;
			stat_r <= RST_REG;
			mask_r <= RST_REG;
			flag_a_r <= 1'h0;
			flag_b_r <= 1'h0;
			c_req_r <= 1'h0;
			irq_r <= 1'h0;
		end else if (ce) begin
			a_fall_r <= a_fall_nxt;
			a_rise_r <= a_rise_nxt;
			b_fall_r <= b_fall_nxt;
			b_rise_r <= b_rise_nxt;
			c_fall_r <= c_fall_nxt;
			c_rise_r <= c_rise_nxt;
			ctrl_r <= ctrl_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			flag_a_r <= flag_a_nxt;
			flag_b_r <= flag_b_nxt;
			c_req_r <= c_req_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign group_a_priority_sel = ctrl_r[CTRL_A_PRIO];
	assign group_a_request_flag = flag_a_r;
	assign group_b_request_flag = flag_b_r;
	assign group_c_request = c_req_r;
	assign irq = irq_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic flag_wr;
	assign flag_wr = wr_en && wr_ok && wr_byte && wr_idx == IDX_TMR_CTRL;

	flag_b_set_a: assert property (ce && ev_b |=> group_b_request_flag)
		else $error("group B event lost");
	flag_b_ack_a: assert property (ce && cpu_ack_b && !ev_b && !flag_wr
		|=> !group_b_request_flag)
		else $error("group B flag not cleared by ack");
	flag_a_set_a: assert property (ce && ev_a |=> group_a_request_flag)
		else $error("group A event lost");
	flag_a_hold_a: assert property (ce && group_a_request_flag && !cpu_ack_a
		&& !flag_wr |=> group_a_request_flag)
		else $error("group A flag dropped without ack");
	a_fall_wr_a: assert property (ce && wr_en && wr_byte && wr_ok
		&& wr_idx == IDX_A_FALL |=> a_fall_r == ($past(wr_data) & MASK_A_EN))
		else $error("group A falling enable not stored");
	a_rise_wr_a: assert property (ce && wr_en && wr_byte && wr_ok
		&& wr_idx == IDX_A_RISE |=> a_rise_r == ($past(wr_data) & MASK_A_EN))
		else $error("group A rising enable not stored");
	b_fall_wr_a: assert property (ce && wr_en && wr_byte && wr_ok
		&& wr_idx == IDX_B_FALL |=> b_fall_r == ($past(wr_data) & MASK_B_EN))
		else $error("group B falling enable not stored");
	b_rise_wr_a: assert property (ce && wr_en && wr_byte && wr_ok
		&& wr_idx == IDX_B_RISE |=> b_rise_r == ($past(wr_data) & MASK_B_EN))
		else $error("group B rising enable not stored");
	c_fall_wr_a: assert property (ce && wr_en && wr_byte && wr_ok
		&& wr_idx == IDX_C_FALL |=> c_fall_r == ($past(wr_data) & MASK_C_EN))
		else $error("group C falling enable not stored");
	c_rise_wr_a: assert property (ce && wr_en && wr_byte && wr_ok
		&& wr_idx == IDX_C_RISE |=> c_rise_r == ($past(wr_data) & MASK_C_EN))
		else $error("group C rising enable not stored");
	c_gate_a: assert property (ce |=> group_c_request ==
		($past(ev_c) && $past(ctrl_r[CTRL_C_EN])))
		else $error("group C request not gated by enable");
	prio_wr_a: assert property (ce && wr_en && wr_byte && wr_ok
		&& wr_idx == IDX_IRQ_CTRL |=> group_a_priority_sel == $past(wr_data[CTRL_A_PRIO]))
		else $error("priority select not written");
	irq_level_a: assert property (irq == |(stat_r & mask_r))
		else $error("interrupt output disagrees with status");

	ev_a_cov: cover property (ce && ev_a ##1 group_a_request_flag ##[1:20] cpu_ack_a);
	ev_c_cov: cover property (ce && group_c_request);
	both_cov: cover property (ce && ev_b && cpu_ack_b);
endmodule

// >>> bench/eeis_pin_model.sv
`timescale 1ns/1ps
// Stand-in for the external pins and the CPU that answers request flags
module eeis_pin_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic flag_a,
	input wire logic flag_b,
	output logic [3:1] lines_a,
	output logic [3:0] lines_b,
	output logic [5:0] lines_c,
	output logic ack_a,
	output logic ack_b
);
	// CPU response time; short values model a prompt CPU, long a busy one
	int ack_delay = 20;
	int cnt_a = 0;
	int cnt_b = 0;
	// Pins idle low until the bench moves them
	initial begin
		lines_a = 3'h0;
		lines_b = 4'h0;
		lines_c = 6'h00;
		ack_a = 1'h0;
		ack_b = 1'h0;
	end
	// Called just after a rising edge so the pin moves off the sampling edge
	task automatic set_line(input int g, input int n, input logic v);
		case (g)
			0: lines_a[n] <= v;
			1: lines_b[n] <= v;
			default: lines_c[n] <= v;
		endcase
	endtask
	// One-cycle answer once a flag has waited ack_delay cycles
	always @(posedge aclk) begin
		ack_a <= aresetn && flag_a && !ack_a && cnt_a + 1 >= ack_delay;
		cnt_a <= (!aresetn || !flag_a || ack_a || cnt_a + 1 >= ack_delay) ? 0 : cnt_a + 1;
		ack_b <= aresetn && flag_b && !ack_b && cnt_b + 1 >= ack_delay;
		cnt_b <= (!aresetn || !flag_b || ack_b || cnt_b + 1 >= ack_delay) ? 0 : cnt_b + 1;
	end
endmodule

// >>> bench/eeis_test.sv
`timescale 1ns/1ps
module eeis_test;
	import eeis_pkg::*;
	logic aclk, aresetn;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [3:1] la;
	logic [3:0] lb;
	logic [5:0] lc;
	logic ack_a, ack_b, flag_a, flag_b, c_req, prio, irq, ce;
	int fail_count = 0;
	int checked = 0;
	int c_cnt = 0;
	logic mask_on, c_on;
	logic [7:0] reg_idx [9] = '{IDX_TMR_CTRL, IDX_A_FALL, IDX_A_RISE, IDX_B_FALL, IDX_B_RISE,
		IDX_C_FALL, IDX_C_RISE, IDX_IRQ_CTRL, IDX_IRQ_MASK};
	logic [7:0] reg_mask [9] = '{MASK_TMR, MASK_A_EN, MASK_A_EN, MASK_B_EN, MASK_B_EN,
		MASK_C_EN, MASK_C_EN, MASK_CTRL, MASK_EV};
	logic [7:0] fall_idx [3] = '{IDX_A_FALL, IDX_B_FALL, IDX_C_FALL};
	logic [7:0] rise_idx [3] = '{IDX_A_RISE, IDX_B_RISE, IDX_C_RISE};

	eeis_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_irq_group_a(la), .ext_irq_group_b(lb), .ext_irq_group_c(lc),
		.cpu_ack_a(ack_a), .cpu_ack_b(ack_b), .group_a_request_flag(flag_a),
		.group_b_request_flag(flag_b), .group_c_request(c_req),
		.group_a_priority_sel(prio), .irq(irq));
	eeis_pin_model u_pins (.aclk(aclk), .aresetn(aresetn), .flag_a(flag_a), .flag_b(flag_b),
		.lines_a(la), .lines_b(lb), .lines_c(lc), .ack_a(ack_a), .ack_b(ack_b));

	// Free-running 100 MHz clock
	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	// Count group C pulses; a one-cycle pulse is easy to miss by sampling
	always @(posedge aclk) if (c_req === 1'h1) c_cnt <= c_cnt + 1;

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Write one word; address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= {24'h000000, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		// No answer time assumed; only the watchdog ends a hung wait
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		resp = bresp;
		bready <= 1'h0;
		// Idle edge, so a next call never re-raises bready in this step
		@(posedge aclk);
		check("bvalid drop", bvalid, 1'h0);
	endtask
	task automatic axi_rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] resp);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata[7:0];
		resp = rresp;
		rready <= 1'h0;
		@(posedge aclk);
		check("rvalid drop", rvalid, 1'h0);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [1:0] r;
		axi_wr(idx, d, r);
		check("bresp", r, RESP_OKAY);
	endtask
	task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		logic [1:0] r;
		axi_rd(idx, d, r);
		check(name, d, exp);
		check("rresp", r, RESP_OKAY);
	endtask

	// Reset values, implemented bits, unmapped place, priority select
	task automatic test_regs();
		logic [7:0] d;
		logic [1:0] r;
		rd_chk("status rst", IDX_IRQ_STAT, RST_REG);
		for (int i = 0; i < 9; i++) begin
			rd_chk("reg rst", reg_idx[i], RST_REG);
			wr(reg_idx[i], 8'hFF);
			rd_chk("reg bits", reg_idx[i], reg_mask[i]);
		end
		check("prio high", prio, 1'h1);
		for (int i = 0; i < 9; i++) wr(reg_idx[i], 8'h00);
		check("prio low", prio, 1'h0);
		axi_rd(8'h00, d, r);
		check("unmapped rresp", r, RESP_SLVERR);
		check("unmapped rdata", d, 8'h00);
		axi_wr(8'h00, 8'hFF, r);
		check("unmapped bresp", r, RESP_SLVERR);
	endtask
	// Move one line and judge flag, irq, pulse, status; then clear and wait for ack
	task automatic edge_step(input int g, input int n, input logic v, input logic exp);
		int c0, i;
		logic [7:0] tc;
		c0 = c_cnt;
		tc = (g < 2 && exp) ? (8'h01 << (g == 0 ? TMR_A_FLAG : TMR_B_FLAG)) : 8'h00;
		u_pins.set_line(g, n, v);
		repeat (4) @(posedge aclk);
		#1;
		check("flag a", flag_a, exp && g == 0);
		check("flag b", flag_b, exp && g == 1);
		check("irq", irq, exp && mask_on);
		check("c pulses", c_cnt - c0, exp && g == 2 && c_on);
		@(posedge aclk);
		rd_chk("flag bits", IDX_TMR_CTRL, tc);
		rd_chk("status", IDX_IRQ_STAT, {5'h00, exp, 2'h0} >> (2 - g));
		wr(IDX_IRQ_STAT, MASK_EV);
		check("irq cleared", irq, 1'h0);
		for (i = 0; i < 60 && (flag_a || flag_b); i++) @(posedge aclk);
		check("flags acked", {flag_a, flag_b}, 2'h0);
	endtask
	// Each line of a group under rise-only, fall-only and both enables
	task automatic test_group(input int g);
		int lo, hi;
		lo = (g == 0) ? 1 : 0;
		hi = (g == 2) ? 5 : 3;
		for (int n = lo; n <= hi; n++) begin
			for (int m = 1; m < 4; m++) begin
				wr(rise_idx[g], m[0] ? 8'h01 << n : 8'h00);
				wr(fall_idx[g], m[1] ? 8'h01 << n : 8'h00);
				edge_step(g, n, 1'h1, m[0]);
				edge_step(g, n, 1'h0, m[1]);
			end
		end
		wr(rise_idx[g], 8'h00);
		wr(fall_idx[g], 8'h00);
	endtask
	// Group C closed and irq masked: status still records the edge
	task automatic test_closed();
		mask_on = 1'h0;
		c_on = 1'h0;
		wr(IDX_IRQ_MASK, 8'h00);
		wr(IDX_IRQ_CTRL, 8'h00);
		wr(IDX_C_RISE, 8'h20);
		edge_step(2, 5, 1'h1, 1'h1);
		edge_step(2, 5, 1'h0, 1'h0);
		wr(IDX_C_RISE, 8'h00);
	endtask
	// Clock enable low freezes detection and ready; the held edge lands on resume
	task automatic test_freeze();
		wr(IDX_B_RISE, 8'h01);
		ce <= 1'h0;
		u_pins.set_line(1, 0, 1'h1);
		repeat (4) @(posedge aclk);
		check("frozen flag b", flag_b, 1'h0);
		check("frozen awready", awready, 1'h0);
		ce <= 1'h1;
		edge_step(1, 0, 1'h1, 1'h1);
		edge_step(1, 0, 1'h0, 1'h0);
		wr(IDX_B_RISE, 8'h00);
	endtask

	// Main sequence
	initial begin
		aresetn <= 1'h0;
		awaddr <= '0;
		araddr <= '0;
		wdata <= 32'h0;
		wstrb <= 4'hF;
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		bready <= 1'h0;
		arvalid <= 1'h0;
		rready <= 1'h0;
		ce <= 1'h1;
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		test_regs();
		mask_on = 1'h1;
		c_on = 1'h1;
		wr(IDX_IRQ_MASK, MASK_EV);
		wr(IDX_IRQ_CTRL, 8'h08);
		for (int g = 0; g < 3; g++) test_group(g);
		test_closed();
		test_freeze();
		results();
	end
	// Whole run needs roughly 2k cycles
	initial begin
		repeat (60000) @(posedge aclk);
		fail_count++;
		results();
	end
endmodule
